// File: rtl/an_ctl_pkg.sv
// constants for the negotiation, crossover and loopback control block
package an_ctl_pkg;
  localparam logic [7:0]  ADDR_BASIC_CONTROL = 8'h00;
  localparam logic [7:0]  ADDR_BASIC_STATUS  = 8'h01;
  localparam logic [7:0]  ADDR_LOCAL_ADVERT  = 8'h04;
  localparam logic [7:0]  ADDR_PARTNER_ABIL  = 8'h05;
  localparam logic [7:0]  ADDR_NEG_EXPANSION = 8'h06;
  localparam logic [7:0]  ADDR_NEXT_PAGE_TX  = 8'h07;
  localparam logic [7:0]  ADDR_PHY_CONTROL   = 8'h10;
  localparam logic [7:0]  ADDR_SELFTEST_LOOP = 8'h16;
  localparam logic [7:0]  ADDR_LOOP_CONFIG   = 8'hFE;
  // basic control fields
  localparam int          BC_LOOP      = 14;
  localparam int          BC_AN_EN     = 12;
  localparam int          BC_RESTART   = 9;
  // basic status
  localparam int          BS_AN_DONE   = 5;
  localparam int          BS_LINK      = 2;
  // advertisement / partner ability
  localparam int          AB_PAUSE     = 10;
  localparam int          AB_ASYM      = 11;
  localparam int          AB_TX_HD     = 7;
  localparam int          AB_10_HD     = 5;
  localparam logic [4:0]  SELECTOR_8023 = 5'h01;
  // expansion
  localparam int          EX_PARTNER_AN = 0;
  localparam int          EX_PD_FAULT   = 4;
  // phy control
  localparam int          PC_AUTO_X    = 6;
  localparam int          PC_FORCE_X   = 5;
  // selftest loop control: loop select in low bits, mii echo to media bit
  localparam int          ST_MII_TX    = 7;
  localparam logic [15:0] RST_BASIC_CONTROL = 16'h1140;
  localparam logic [15:0] RST_LOCAL_ADVERT  = 16'h01E1;
  localparam logic [15:0] RST_PHY_CONTROL   = 16'h0040;
  localparam logic [15:0] RST_LOOP_CONFIG   = 16'hE721;
  localparam logic [15:0] RST_NEXT_PAGE     = 16'h2001;
  // timing
  localparam int          CLK_HZ           = 50_000_000;
  localparam int          BREAK_LINK_MS    = 1500;
  localparam int          BREAK_LINK_CYC   = CLK_HZ / 1000 * BREAK_LINK_MS;
  localparam int          AN_TIMEOUT_MS    = 3000;
  localparam int          AN_TIMEOUT_CYC   = CLK_HZ / 1000 * AN_TIMEOUT_MS;
  localparam int          MDIX_SLOT_MS     = 80;
  localparam int          MDIX_SLOT_CYC    = CLK_HZ / 1000 * MDIX_SLOT_MS;
  // loopback select codes
  typedef enum logic [2:0] {
    LB_NONE    = 3'b000,
    LB_MII     = 3'b001,
    LB_PCS     = 3'b010,
    LB_DIGITAL = 3'b011,
    LB_ANALOG  = 3'b100,
    LB_EXTERN  = 3'b101
  } loop_t;
  typedef enum logic [2:0] {
    AN_IDLE    = 3'b000,
    AN_BREAK   = 3'b001,
    AN_MDIX    = 3'b010,
    AN_ABILITY = 3'b011,
    AN_NEXTPG  = 3'b100,
    AN_GOOD    = 3'b101
  } an_state_t;
  typedef enum logic [1:0] {
    SPD_10   = 2'b00,
    SPD_100  = 2'b01,
    SPD_1000 = 2'b10
  } speed_t;
endpackage : an_ctl_pkg

// File: rtl/an_ctl.sv
// negotiation, crossover and loopback control with management registers

// Overview of operation
// - advertise pause bits 10, 11 of advertisement
// - partner pause bits stored in partner ability
// - next pages sent from next page register
// - parallel detect sets partner bits 5, 7
// - parallel detect loads selector 00001
// - expansion bit0 zero after parallel detect
// - parallel detect fault on non-good link
// - lost negotiated link resumes negotiation
// - writing restart bit restarts negotiation
// - restart silences link until break timer
// - strap-disabled negotiation stays disabled
// - negotiation times out within three seconds
// - crossover resolved before ability exchange
// - auto crossover enable and forced mode
// - crossover independent of negotiation at 10/100
// - mii loop in basic control, others selftest
// - loopback availability per speed and interface
// - mii loop returns data, optional media echo
module an_ctl #(
  parameter int BREAK_CYC = an_ctl_pkg::BREAK_LINK_CYC,
  parameter int TIMEOUT_CYC = an_ctl_pkg::AN_TIMEOUT_CYC,
  parameter int MDIX_CYC = an_ctl_pkg::MDIX_SLOT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        an_disable_strap,
  input  wire logic        serial_mac,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        energy_seen,
  input  wire logic        flp_seen,
  input  wire logic [15:0] partner_page,
  input  wire logic        partner_page_valid,
  input  wire logic        partner_np,
  input  wire logic        pd_link_10,
  input  wire logic        pd_link_100,
  input  wire logic        pd_multi,
  input  wire logic        link_good,
  input  wire logic [1:0]  resolved_speed,
  output logic             link_pulses_en,
  output logic             data_tx_en,
  output logic      [15:0] tx_page,
  output logic             tx_page_strobe,
  output logic             mdix_sel,
  output logic      [2:0]  loop_sel,
  output logic             loop_media_echo,
  output logic             loop_link_ok
);
  an_ctl_pkg::an_state_t st_r;
  logic [15:0] ctl_r, adv_r, lpa_r, np_r, phy_r, st_ctl_r, lcfg_r;
  logic        an_done_r, pd_r, pdf_r, partner_an_r, mdix_r, strap_r;
  logic        link_r, lp_np_r, strap_seen_r;
  logic [31:0] tmr_r;
  logic        wr_ctl, restart_req, an_en, pd_hit;
  logic [2:0]  lb_req;

  assign wr_ctl = reg_wr && reg_addr == an_ctl_pkg::ADDR_BASIC_CONTROL;
  assign an_en = ctl_r[an_ctl_pkg::BC_AN_EN] && strap_seen_r && !strap_r;
  assign restart_req = wr_ctl && reg_wdata[an_ctl_pkg::BC_RESTART];
  assign pd_hit = pd_link_10 || pd_link_100;

  // strap caught after reset release
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      strap_seen_r <= 1'b0;
      strap_r <= 1'b0;
    end else if (!strap_seen_r) begin
      strap_seen_r <= 1'b1;
      strap_r <= an_disable_strap;
    end
  end

  // control register; enable bit locked by strap
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_r <= an_ctl_pkg::RST_BASIC_CONTROL;
    end else if (!strap_seen_r) begin
      ctl_r <= an_ctl_pkg::RST_BASIC_CONTROL;
    end else if (wr_ctl) begin
      ctl_r <= reg_wdata;
      ctl_r[an_ctl_pkg::BC_RESTART] <= 1'b0;
      if (strap_r) begin
        ctl_r[an_ctl_pkg::BC_AN_EN] <= 1'b0;
      end
    end else if (strap_r) begin
      ctl_r[an_ctl_pkg::BC_AN_EN] <= 1'b0;
    end
  end

  // writable registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      adv_r <= an_ctl_pkg::RST_LOCAL_ADVERT;
      np_r <= an_ctl_pkg::RST_NEXT_PAGE;
      phy_r <= an_ctl_pkg::RST_PHY_CONTROL;
      st_ctl_r <= 16'h0000;
      lcfg_r <= an_ctl_pkg::RST_LOOP_CONFIG;
    end else if (reg_wr) begin
      case (reg_addr)
        an_ctl_pkg::ADDR_LOCAL_ADVERT: adv_r <= reg_wdata;
        an_ctl_pkg::ADDR_NEXT_PAGE_TX: np_r <= reg_wdata;
        an_ctl_pkg::ADDR_PHY_CONTROL: phy_r <= reg_wdata;
        an_ctl_pkg::ADDR_SELFTEST_LOOP: st_ctl_r <= reg_wdata;
        an_ctl_pkg::ADDR_LOOP_CONFIG: lcfg_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // negotiation sequencer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= an_ctl_pkg::AN_IDLE;
      tmr_r <= 32'h0000_0000;
      an_done_r <= 1'b0;
      pd_r <= 1'b0;
      partner_an_r <= 1'b0;
      lp_np_r <= 1'b0;
    end else if (!an_en) begin
      st_r <= an_ctl_pkg::AN_IDLE;
      tmr_r <= 32'h0000_0000;
      an_done_r <= 1'b0;
    end else if (restart_req) begin
      st_r <= an_ctl_pkg::AN_BREAK;
      tmr_r <= 32'h0000_0000;
      an_done_r <= 1'b0;
    end else begin
      tmr_r <= tmr_r + 32'h0000_0001;
      case (st_r)
        an_ctl_pkg::AN_IDLE: begin
          st_r <= an_ctl_pkg::AN_MDIX;
          tmr_r <= 32'h0000_0000;
        end
        an_ctl_pkg::AN_BREAK: begin
          if (tmr_r >= 32'(BREAK_CYC - 1)) begin
            st_r <= an_ctl_pkg::AN_MDIX;
            tmr_r <= 32'h0000_0000;
          end
        end
        an_ctl_pkg::AN_MDIX: begin
          if (energy_seen) begin
            st_r <= an_ctl_pkg::AN_ABILITY;
            tmr_r <= 32'h0000_0000;
          end
        end
        an_ctl_pkg::AN_ABILITY: begin
          if (partner_page_valid) begin
            partner_an_r <= 1'b1;
            pd_r <= 1'b0;
            lp_np_r <= partner_np;
            st_r <= (partner_np || adv_r[15]) ? an_ctl_pkg::AN_NEXTPG
                                              : an_ctl_pkg::AN_GOOD;
            an_done_r <= !(partner_np || adv_r[15]);
          end else if (pd_hit && !pd_multi) begin
            partner_an_r <= 1'b0;
            pd_r <= 1'b1;
            st_r <= an_ctl_pkg::AN_GOOD;
            an_done_r <= 1'b1;
          end else if (tmr_r >= 32'(TIMEOUT_CYC - 1)) begin
            st_r <= an_ctl_pkg::AN_BREAK;
            tmr_r <= 32'h0000_0000;
          end
        end
        an_ctl_pkg::AN_NEXTPG: begin
          if (partner_page_valid && !partner_np && !np_r[15]) begin
            st_r <= an_ctl_pkg::AN_GOOD;
            an_done_r <= 1'b1;
          end else if (tmr_r >= 32'(TIMEOUT_CYC - 1)) begin
            st_r <= an_ctl_pkg::AN_BREAK;
            tmr_r <= 32'h0000_0000;
          end
        end
        an_ctl_pkg::AN_GOOD: begin
          if (link_r && !link_good) begin
            st_r <= an_ctl_pkg::AN_MDIX;
            an_done_r <= 1'b0;
            tmr_r <= 32'h0000_0000;
          end
        end
        default: st_r <= an_ctl_pkg::AN_IDLE;
      endcase
    end
  end

  // partner ability capture
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      lpa_r <= 16'h0000;
    end else if (st_r == an_ctl_pkg::AN_ABILITY && partner_page_valid) begin
      lpa_r <= partner_page;
    end else if (st_r == an_ctl_pkg::AN_ABILITY && pd_hit && !pd_multi) begin
      lpa_r <= 16'h0000;
      lpa_r[an_ctl_pkg::AB_TX_HD] <= pd_link_100;
      lpa_r[an_ctl_pkg::AB_10_HD] <= pd_link_10 && !pd_link_100;
      lpa_r[4:0] <= an_ctl_pkg::SELECTOR_8023;
    end
  end

  // link tracking and parallel detect fault, set wins over read clear
  logic rd_exp;
  assign rd_exp = reg_rd && reg_addr == an_ctl_pkg::ADDR_NEG_EXPANSION;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link_r <= 1'b0;
      pdf_r <= 1'b0;
    end else begin
      link_r <= link_good && an_done_r;
      if (st_r == an_ctl_pkg::AN_ABILITY && pd_hit && pd_multi) begin
        pdf_r <= 1'b1;
      end else if (st_r == an_ctl_pkg::AN_GOOD && pd_r && !link_good) begin
        pdf_r <= 1'b1;
      end else if (rd_exp) begin
        pdf_r <= 1'b0;
      end
    end
  end

  // crossover: toggles per slot while hunting, holds once energy or link is seen, forced when auto crossover is off
  logic [31:0] mdx_tmr_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mdix_r <= 1'b0;
      mdx_tmr_r <= 32'h0000_0000;
    end else if (!phy_r[an_ctl_pkg::PC_AUTO_X]) begin
      mdix_r <= phy_r[an_ctl_pkg::PC_FORCE_X];
      mdx_tmr_r <= 32'h0000_0000;
    end else if (!energy_seen && !link_good) begin
      // hunting runs whether negotiation is on or speed is forced
      if (mdx_tmr_r >= 32'(MDIX_CYC - 1)) begin
        mdx_tmr_r <= 32'h0000_0000;
        mdix_r <= !mdix_r;
      end else begin
        mdx_tmr_r <= mdx_tmr_r + 32'h0000_0001;
      end
    end
  end

  // loopback select and availability
  function automatic logic lb_ok(input logic [2:0] m, input logic [1:0] sp,
                                 input logic ser);
    lb_ok = 1'b1;
    if (sp == an_ctl_pkg::SPD_10 && ser) lb_ok = 1'b0;
    if (m == an_ctl_pkg::LB_PCS && sp == an_ctl_pkg::SPD_10) lb_ok = 1'b0;
    if (m == an_ctl_pkg::LB_EXTERN && sp == an_ctl_pkg::SPD_1000) begin
      lb_ok = 1'b0;
    end
  endfunction : lb_ok

  always_comb begin
    lb_req = an_ctl_pkg::LB_NONE;
    if (ctl_r[an_ctl_pkg::BC_LOOP]) begin
      lb_req = an_ctl_pkg::LB_MII;
    end else if (st_ctl_r[2:0] >= 3'h2 && st_ctl_r[2:0] <= 3'h5) begin
      lb_req = st_ctl_r[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      loop_sel <= an_ctl_pkg::LB_NONE;
      loop_link_ok <= 1'b0;
      loop_media_echo <= 1'b0;
    end else if (lb_ok(lb_req, resolved_speed, serial_mac)) begin
      loop_sel <= lb_req;
      loop_link_ok <= lb_req != an_ctl_pkg::LB_MII &&
                      !(lb_req == an_ctl_pkg::LB_PCS &&
                        resolved_speed == an_ctl_pkg::SPD_1000);
      loop_media_echo <= lb_req == an_ctl_pkg::LB_MII &&
                         st_ctl_r[an_ctl_pkg::ST_MII_TX];
    end else begin
      loop_sel <= an_ctl_pkg::LB_NONE;
      loop_link_ok <= 1'b0;
      loop_media_echo <= 1'b0;
    end
  end

  // link side outputs
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      link_pulses_en <= 1'b0;
      data_tx_en <= 1'b0;
      tx_page <= 16'h0000;
      tx_page_strobe <= 1'b0;
      mdix_sel <= 1'b0;
    end else begin
      link_pulses_en <= an_en && st_r != an_ctl_pkg::AN_BREAK;
      data_tx_en <= st_r != an_ctl_pkg::AN_BREAK &&
                    (!an_en || st_r == an_ctl_pkg::AN_GOOD);
      tx_page_strobe <= (st_r == an_ctl_pkg::AN_ABILITY ||
                         st_r == an_ctl_pkg::AN_NEXTPG) && flp_seen;
      tx_page <= st_r == an_ctl_pkg::AN_NEXTPG ? np_r : adv_r;
      mdix_sel <= mdix_r;
    end
  end

  // read mux
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        an_ctl_pkg::ADDR_BASIC_CONTROL: reg_rdata <= ctl_r;
        an_ctl_pkg::ADDR_BASIC_STATUS: reg_rdata <=
          {10'h3C0, an_done_r, 2'h1, link_r, 2'h1};
        an_ctl_pkg::ADDR_LOCAL_ADVERT: reg_rdata <= adv_r;
        an_ctl_pkg::ADDR_PARTNER_ABIL: reg_rdata <= lpa_r;
        an_ctl_pkg::ADDR_NEG_EXPANSION: reg_rdata <=
          {11'h000, pdf_r, lp_np_r, 1'b1, 1'b0, partner_an_r};
        an_ctl_pkg::ADDR_NEXT_PAGE_TX: reg_rdata <= np_r;
        an_ctl_pkg::ADDR_PHY_CONTROL: reg_rdata <= phy_r;
        an_ctl_pkg::ADDR_SELFTEST_LOOP: reg_rdata <= st_ctl_r;
        an_ctl_pkg::ADDR_LOOP_CONFIG: reg_rdata <= lcfg_r;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  strap_lock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    strap_r && strap_seen_r |=> !ctl_r[an_ctl_pkg::BC_AN_EN])
    else $error("negotiation enabled despite strap");
  restart_break_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    restart_req && an_en |=> st_r == an_ctl_pkg::AN_BREAK ##1
    !link_pulses_en)
    else $error("restart did not silence link");
  pd_selector_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(pd_r) |-> lpa_r[4:0] == an_ctl_pkg::SELECTOR_8023)
    else $error("selector not loaded on parallel detect");
  pd_expansion_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pd_r && an_done_r |-> !partner_an_r)
    else $error("expansion bit0 set after parallel detect");
  link_resume_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_r == an_ctl_pkg::AN_GOOD && link_r && !link_good && an_en &&
    !restart_req |=> st_r == an_ctl_pkg::AN_MDIX)
    else $error("lost link did not resume negotiation");
  forced_mdix_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !phy_r[an_ctl_pkg::PC_AUTO_X] ##1 !phy_r[an_ctl_pkg::PC_AUTO_X] |=>
    mdix_sel == $past(phy_r[an_ctl_pkg::PC_FORCE_X], 2))
    else $error("forced crossover not applied");
  mii_nolink_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    loop_sel == an_ctl_pkg::LB_MII |-> !loop_link_ok)
    else $error("mii loop reports link");
  ext_gig_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    loop_sel == an_ctl_pkg::LB_EXTERN |->
    $past(resolved_speed) != an_ctl_pkg::SPD_1000)
    else $error("external loop at gigabit");
  pdf_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    st_r == an_ctl_pkg::AN_ABILITY && pd_hit && pd_multi && an_en &&
    !restart_req |=> pdf_r)
    else $error("parallel detect fault not set");
  cov_pd_c: cover property (@(posedge sys_clk) $rose(pd_r));
  cov_np_c: cover property (@(posedge sys_clk)
    st_r == an_ctl_pkg::AN_NEXTPG ##1 st_r == an_ctl_pkg::AN_GOOD);
  cov_break_c: cover property (@(posedge sys_clk)
    st_r == an_ctl_pkg::AN_BREAK ##1 st_r == an_ctl_pkg::AN_MDIX);
  cov_mii_c: cover property (@(posedge sys_clk) loop_media_echo);
endmodule : an_ctl

// File: dv/link_partner_model.sv
// behavioural link partner on the far side of the media
module link_partner_model (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [2:0]  mode,
  input  wire logic [1:0]  speed,
  input  wire logic [15:0] page,
  input  wire logic        tx_page_strobe,
  output logic             energy_seen,
  output logic             flp_seen,
  output logic      [15:0] partner_page,
  output logic             partner_page_valid,
  output logic             partner_np,
  output logic             pd_link_10,
  output logic             pd_link_100,
  output logic             pd_multi,
  output logic             link_good,
  output logic      [1:0]  resolved_speed
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 0 quiet, 1 negotiating, 2 forced 100, 3 ambiguous signalling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      energy_seen        <= 1'b0;
      flp_seen           <= 1'b0;
      partner_page       <= 16'h0000;
      partner_page_valid <= 1'b0;
      partner_np         <= 1'b0;
      pd_link_10         <= 1'b0;
      pd_link_100        <= 1'b0;
      pd_multi           <= 1'b0;
      link_good          <= 1'b0;
      resolved_speed     <= 2'h0;
    end else begin
      energy_seen        <= (mode != 3'h0);
      flp_seen           <= (mode == 3'h1);
      pd_link_100        <= (mode == 3'h2) || (mode == 3'h3);
      pd_link_10         <= (mode == 3'h3);
      pd_multi           <= (mode == 3'h3);
      partner_np         <= 1'b0;
      resolved_speed     <= speed;
      // page answers each base page; line toggles when not valid
      partner_page_valid <= (mode == 3'h1) && tx_page_strobe;
      partner_page       <= ((mode == 3'h1) && tx_page_strobe) ?
                            page : ~partner_page;
      link_good          <= (mode == 3'h2) ||
                            ((mode == 3'h1) && (partner_page_valid || link_good));
    end
  end
endmodule : link_partner_model

// File: dv/test_an_ctl.sv
// testbench for the negotiation, crossover and loopback control block
module test_an_ctl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        strap = 1'b0;
  logic        serial_mac = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [2:0]  mode = 3'h0;
  logic [1:0]  speed = 2'h1;
  logic [15:0] rd_val;
  wire  [15:0] reg_rdata, partner_page, tx_page;
  wire  [1:0]  resolved_speed;
  wire  [2:0]  loop_sel;
  wire         energy_seen, flp_seen, partner_page_valid, partner_np;
  wire         pd_link_10, pd_link_100, pd_multi, link_good;
  wire         link_pulses_en, data_tx_en, tx_page_strobe, mdix_sel;
  wire         loop_media_echo, loop_link_ok;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  // serial, speed, code, expected selection
  logic [8:0]  lb_tab [0:6] = '{9'b0_00_010_000, 9'b0_01_010_010,
    9'b0_10_101_000, 9'b0_01_101_101, 9'b0_00_011_011, 9'b1_00_011_000,
    9'b1_10_100_100};

  an_ctl #(.BREAK_CYC(20), .TIMEOUT_CYC(200), .MDIX_CYC(10)) i_dut (
    .sys_clk(sys_clk), .nrst(nrst), .an_disable_strap(strap),
    .serial_mac(serial_mac), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .energy_seen(energy_seen), .flp_seen(flp_seen),
    .partner_page(partner_page), .partner_page_valid(partner_page_valid),
    .partner_np(partner_np), .pd_link_10(pd_link_10),
    .pd_link_100(pd_link_100), .pd_multi(pd_multi), .link_good(link_good),
    .resolved_speed(resolved_speed), .link_pulses_en(link_pulses_en),
    .data_tx_en(data_tx_en), .tx_page(tx_page),
    .tx_page_strobe(tx_page_strobe), .mdix_sel(mdix_sel),
    .loop_sel(loop_sel), .loop_media_echo(loop_media_echo),
    .loop_link_ok(loop_link_ok));

  link_partner_model i_partner (
    .sys_clk(sys_clk), .nrst(nrst), .mode(mode), .speed(speed),
    .page(16'h0C01), .tx_page_strobe(tx_page_strobe),
    .energy_seen(energy_seen), .flp_seen(flp_seen),
    .partner_page(partner_page), .partner_page_valid(partner_page_valid),
    .partner_np(partner_np), .pd_link_10(pd_link_10),
    .pd_link_100(pd_link_100), .pd_multi(pd_multi), .link_good(link_good),
    .resolved_speed(resolved_speed));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    #1 rd_val = reg_rdata;
    @(posedge sys_clk);
  endtask : reg_read

  task automatic do_reset(input logic s);
    nrst  <= 1'b0;
    strap <= s;
    repeat (3) @(posedge sys_clk);
    nrst  <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : do_reset

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    do_reset(1'b0);
    reg_read(8'h00); check("basic_control", rd_val, 16'h1140);
    reg_read(8'h04); check("advert", rd_val, 16'h01E1);
    reg_read(8'h10); check("phy_control", rd_val, 16'h0040);
    reg_read(8'hFE); check("loop_cfg", rd_val, 16'hE721);
    reg_read(8'h07); check("next_page", rd_val, 16'h2001);
    reg_read(8'h20); check("unmapped", rd_val, 16'h0000);
    #1 n = int'(mdix_sel);
    repeat (10) @(posedge sys_clk);
    #1 check("auto_x", 16'(n != int'(mdix_sel)), 16'h0001);
    reg_write(8'h07, 16'h2ABC);
    reg_read(8'h07); check("next_page_rw", rd_val, 16'h2ABC);
    mode <= 3'h1;
    reg_write(8'h04, 16'h8DE1);
    reg_write(8'h00, 16'h1340);
    repeat (2) @(posedge sys_clk);
    #1 check("pulses_off", 16'(link_pulses_en), 16'h0000);
    check("data_off", 16'(data_tx_en), 16'h0000);
    n = 0;
    while (link_pulses_en !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("break_len", 16'(n >= 18 && n <= 40), 16'h0001);
    n = 0;
    while (tx_page_strobe !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      #1 n++;
    end
    check("strobe_seen", 16'(tx_page_strobe), 16'h0001);
    check("base_page", tx_page, 16'h8DE1);
    repeat (3) @(posedge sys_clk);
    #1 check("next_page_tx", tx_page, 16'h2ABC);
    repeat (10) @(posedge sys_clk);
    #1 check("data_on", 16'(data_tx_en), 16'h0001);
    reg_read(8'h05); check("partner_abil", rd_val, 16'h0C01);
    reg_write(8'h05, 16'hFFFF);
    reg_read(8'h05); check("partner_ro", rd_val, 16'h0C01);
    mode <= 3'h2;
    reg_write(8'h00, 16'h1340);
    repeat (600) @(posedge sys_clk);
    reg_read(8'h05); check("pd_abil", rd_val, 16'h0081);
    reg_read(8'h01); check("an_done", 16'(rd_val[5]), 16'h0001);
    reg_read(8'h06); check("pd_exp0", 16'(rd_val[0]), 16'h0000);
    mode <= 3'h3;
    reg_write(8'h00, 16'h1340);
    repeat (600) @(posedge sys_clk);
    reg_read(8'h06); check("pd_fault", 16'(rd_val[4]), 16'h0001);
    mode <= 3'h0;
    reg_write(8'h00, 16'h0000);
    reg_write(8'h10, 16'h0020);
    repeat (2) @(posedge sys_clk);
    #1 check("forced_x", 16'(mdix_sel), 16'h0001);
    reg_write(8'h10, 16'h0000);
    repeat (2) @(posedge sys_clk);
    #1 check("forced_s", 16'(mdix_sel), 16'h0000);
    reg_write(8'hFE, 16'hE720);
    reg_read(8'hFE); check("loop_cfg_rw", rd_val, 16'hE720);
    for (int i = 0; i < 7; i++) begin
      serial_mac <= lb_tab[i][8];
      speed      <= lb_tab[i][7:6];
      reg_write(8'h16, {13'h0000, lb_tab[i][5:3]});
      repeat (4) @(posedge sys_clk);
      #1 check("loop_sel", loop_sel, {13'h0000, lb_tab[i][2:0]});
      check("lb_link", 16'(loop_link_ok), 16'(lb_tab[i][2:0] != 3'h0));
    end
    serial_mac <= 1'b0;
    reg_write(8'h16, 16'h0080);
    reg_write(8'h00, 16'h4000);
    repeat (4) @(posedge sys_clk);
    #1 check("mii_sel", loop_sel, 16'h0001);
    check("mii_echo", 16'(loop_media_echo), 16'h0001);
    check("mii_link", 16'(loop_link_ok), 16'h0000);
    do_reset(1'b1);
    reg_write(8'h00, 16'h0000);
    reg_write(8'h00, 16'h1000);
    reg_read(8'h00); check("strap_an", 16'(rd_val[12]), 16'h0000);
    summarize();
  end
endmodule : test_an_ctl
